// [hdl/shk_station.sv]
// station side control: attention request, interlocked group handshake, keyboard buffer
// assumes all pins are asynchronous to CLK_SYS_I and the controller card keeps its own rules
`timescale 1ns/1ns
module shk_station (
    input wire logic CLK_SYS_I, // 100 MHz system clock
    input wire logic RST_N_I, // async reset, active low
    input wire logic RECORD_CMD_I, // voltmeter reading ready
    input wire logic KEY_SEND_I, // send key contact
    input wire logic KEY_REQUEST_I, // request key contact
    input wire logic KEY_BACK_I, // backspace key contact
    input wire logic KEY_RESET_I, // reset key contact
    input wire logic KEY_MODE_I, // mode key contact
    input wire logic [shk_pkg::NUM_KEYS-1:0] KEY_DIGIT_I, // numeric key contacts
    input wire logic [shk_pkg::VM_W-1:0] VM_DATA_I, // voltmeter eight digits
    input wire logic ACCEPT_ACK_I, // accept from controller
    input wire logic GROUP_TAKEN_I, // group taken from controller
    output shk_pkg::shk_cable_t CABLE_O, // cable side outputs
    output logic RX_ENABLE_O, // line receiver interlock
    output logic CHANNEL_ADVANCE_O, // scanner step pulse
    output logic MODE_SOURCE_O, // high in source mode
    output logic [2:0] MUX_ADDR_O, // multiplexer address
    output shk_pkg::shk_kbd_t KBD_O // keyboard buffer view
);
    import shk_pkg::*;

    typedef struct packed {
        shk_pins_t s1, s2, s3, flt;
        logic [VM_W-1:0] vm1, vm2, vm3, vm_cap;
        logic [POR_W-1:0] por_cnt;
        logic mode_src, rx_en, xfer_pend, rdy, chan_adv, kdir, kstb;
        shk_hs_t hs;
        shk_ks_t ks;
        logic [2:0] push_cnt, taken_cnt;
        logic [GROUP_W-1:0] cab_data;
        logic [1:0][GROUP_W-1:0] buf_mem;
        logic buf_wp, buf_rp;
        logic [1:0] buf_cnt;
        logic [SEL_W-1:0] sel;
        logic [NUM_LATCH-1:0][DIGIT_W-1:0] latch;
        logic [DIGIT_W-1:0] kcode;
    } shk_st_t;

    shk_st_t st_q, st_d;
    shk_pins_t pins;
    logic gen_rst, acc, taken, push, pop, buf_clr;
    logic [2:0] mux_addr;
    logic [GROUP_W-1:0] grp_word;
    logic [DIGIT_W-1:0] bcd;

    assign pins = {KEY_DIGIT_I, GROUP_TAKEN_I, ACCEPT_ACK_I, KEY_MODE_I, KEY_RESET_I,
                   KEY_BACK_I, KEY_REQUEST_I, KEY_SEND_I, RECORD_CMD_I};

    // one digit of the eight-digit block, digit 0 first
    function automatic logic [DIGIT_W-1:0] block_digit(input logic src, input logic [2:0] idx,
            input logic [VM_W-1:0] vm, input logic [NUM_LATCH-1:0][DIGIT_W-1:0] lt);
        logic [DIGIT_W-1:0] d;
        d = vm[VM_W-1-DIGIT_W*idx -: DIGIT_W];
        if (!src) begin
            if (idx == 3'h0) begin
                d = FUNC_MANUAL;
            end else if (idx == 3'h1) begin
                d = lt[EXP_LATCH];
            end else begin
                d = lt[idx - 3'h2];
            end
        end
        return d;
    endfunction : block_digit

    // 1248 encoder, lowest pressed key wins
    always_comb begin
        bcd = 4'h0;
        for (int k = NUM_KEYS - 1; k >= 0; k--) begin
            if (st_q.flt[PIN_DIGIT0 + k]) begin
                bcd = k[DIGIT_W-1:0]; // RL13
            end
        end
    end

    // filtered levels: receivers gated by the interlock so stray lines cannot act
    assign acc = st_q.flt[PIN_ACCEPT] & st_q.rx_en; // RL12
    assign taken = st_q.flt[PIN_TAKEN] & st_q.rx_en; // RL12
    assign gen_rst = (st_q.por_cnt != '0) || st_q.flt[PIN_RESET]; // RL21
    assign buf_clr = gen_rst || (st_q.hs == HS_DONE && !st_q.mode_src); // RL16
    assign mux_addr = (st_q.mode_src ? MUX_SRC_BASE : 3'h0) | {1'b0, st_q.push_cnt[1:0]}; // RL11
    assign grp_word = {block_digit(st_q.mode_src, {st_q.push_cnt[1:0], 1'b0}, st_q.vm_cap,
                                   st_q.latch),
                       block_digit(st_q.mode_src, {st_q.push_cnt[1:0], 1'b1}, st_q.vm_cap,
                                   st_q.latch)}; // RL22
    // buffer fills while the block is running, drains only between handshakes
    assign push = st_q.hs == HS_XFER && st_q.push_cnt < LAST_TAKEN && st_q.buf_cnt != BUF_FULL;
    assign pop = st_q.hs == HS_XFER && !st_q.rdy && !taken && st_q.buf_cnt != 2'h0; // RL3

    always_comb begin
        st_d = st_q;
        st_d.chan_adv = 1'b0;
        st_d.kstb = 1'b0;
        // three-stage pin filter, a change counts once stages two and three agree
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.flt = (st_q.s2 & st_q.s3) | (st_q.flt & (st_q.s2 | st_q.s3)); // RL20
        st_d.vm1 = VM_DATA_I;
        st_d.vm2 = st_q.vm1;
        st_d.vm3 = st_q.vm2;
        if (st_q.por_cnt != '0) begin
            st_d.por_cnt = st_q.por_cnt - 1'b1; // RL21
        end
        // mode storage toggles on each press of the mode key
        if (st_d.flt[PIN_MODE] && !st_q.flt[PIN_MODE]) begin
            st_d.mode_src = !st_q.mode_src; // RL23
        end

        // handshake sequencer
        case (st_q.hs)
            HS_IDLE: begin
                if (!acc && st_d.flt[PIN_RECORD] && !st_q.flt[PIN_RECORD] && st_q.mode_src) begin
                    st_d.vm_cap = st_q.vm3;
                    st_d.hs = HS_ATTN; // RL1
                    st_d.xfer_pend = 1'b1;
                    st_d.rx_en = 1'b1; // RL12
                end else if (!acc && st_d.flt[PIN_SEND] && !st_q.flt[PIN_SEND]
                             && !st_q.mode_src) begin
                    st_d.hs = HS_ATTN; // RL2
                    st_d.xfer_pend = 1'b1;
                    st_d.rx_en = 1'b1;
                end else if (!acc && st_d.flt[PIN_REQUEST] && !st_q.flt[PIN_REQUEST]) begin
                    st_d.hs = HS_ATTN; // request only checks the computer is there
                    st_d.xfer_pend = 1'b0;
                    st_d.rx_en = 1'b1;
                end
            end
            HS_ATTN: begin
                if (acc) begin
                    st_d.hs = st_q.xfer_pend ? HS_XFER : HS_IDLE; // RL6
                    st_d.push_cnt = 3'h0;
                    st_d.taken_cnt = 3'h0;
                end
            end
            HS_XFER: begin
                if (st_q.rdy && taken) begin
                    st_d.rdy = 1'b0; // RL9
                    st_d.taken_cnt = st_q.taken_cnt + 3'h1;
                    if (st_q.taken_cnt == LAST_TAKEN - 3'h1) begin
                        st_d.hs = HS_DONE; // RL9
                    end
                end
            end
            HS_DONE: begin
                st_d.chan_adv = st_q.mode_src; // RL10
                st_d.xfer_pend = 1'b0;
                st_d.hs = HS_IDLE;
            end
            default: begin
                st_d.hs = HS_IDLE;
            end
        endcase

        // two-entry group buffer between the selector and the cable
        if (push) begin
            st_d.buf_mem[st_q.buf_wp] = grp_word;
            st_d.buf_wp = !st_q.buf_wp;
            st_d.push_cnt = st_q.push_cnt + 3'h1;
        end
        if (pop) begin
            st_d.cab_data = st_q.buf_mem[st_q.buf_rp];
            st_d.buf_rp = !st_q.buf_rp;
            st_d.rdy = 1'b1; // RL8
        end
        st_d.buf_cnt = st_q.buf_cnt + {1'b0, push} - {1'b0, pop};

        // keyboard: a press starts a two-pulse sequence whose order depends on direction
        case (st_q.ks)
            KS_IDLE: begin
                if (st_d.flt[PIN_DIGIT0 +: NUM_KEYS] != '0
                    && st_q.flt[PIN_DIGIT0 +: NUM_KEYS] == '0 && !st_q.sel[SEL_W-1]) begin
                    st_d.kstb = 1'b1; // RL13
                    st_d.kdir = 1'b0;
                    st_d.ks = KS_ONE;
                end else if (st_d.flt[PIN_BACK] && !st_q.flt[PIN_BACK]
                             && st_q.sel != SEL_HOME) begin
                    st_d.kdir = 1'b1; // RL19
                    st_d.ks = KS_ONE;
                end
            end
            KS_ONE: begin
                st_d.kcode = bcd;
                if (!st_q.kdir) begin
                    st_d.sel = {st_q.sel[SEL_W-2:0], 1'b0}; // RL17
                end else begin
                    for (int i = 0; i < NUM_LATCH; i++) begin
                        if (st_q.sel[i+1]) begin
                            st_d.latch[i] = '0; // RL18
                        end
                    end
                end
                st_d.ks = KS_TWO;
            end
            KS_TWO: begin
                if (!st_q.kdir) begin
                    for (int i = 0; i < NUM_LATCH; i++) begin
                        if (st_q.sel[i+1]) begin
                            st_d.latch[i] = st_q.kcode; // RL17
                        end
                    end
                end else begin
                    st_d.sel = {1'b0, st_q.sel[SEL_W-1:1]}; // RL18
                end
                st_d.ks = KS_IDLE;
            end
            default: begin
                st_d.ks = KS_IDLE;
            end
        endcase

        // clear wins over any key step in the same cycle
        if (buf_clr) begin
            st_d.sel = SEL_HOME; // RL16
            st_d.latch = '0;
            st_d.ks = KS_IDLE;
        end
        if (gen_rst) begin
            st_d.mode_src = 1'b0; // RL23
            st_d.rx_en = 1'b0; // RL12
            st_d.hs = HS_IDLE;
            st_d.rdy = 1'b0;
            st_d.buf_cnt = 2'h0;
            st_d.buf_wp = 1'b0;
            st_d.buf_rp = 1'b0;
            st_d.xfer_pend = 1'b0;
            st_d.chan_adv = 1'b0;
        end
    end

    // single state register, reset arms the power-on stretch
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q <= '0;
            st_q.por_cnt <= POR_W'(POR_CYCLES); // RL21
            st_q.sel <= SEL_HOME;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs; shift and write pulses are plain decodes of the key sequencer state, strobe and channel advance are registered
    assign CABLE_O.attn_req = st_q.hs == HS_ATTN; // RL1
    assign CABLE_O.driver_enable_line = st_q.hs == HS_XFER || st_q.hs == HS_DONE; // RL6
    assign CABLE_O.group_ready = st_q.rdy; // RL8
    assign CABLE_O.data = st_q.cab_data;
    assign RX_ENABLE_O = st_q.rx_en;
    assign CHANNEL_ADVANCE_O = st_q.chan_adv;
    assign MODE_SOURCE_O = st_q.mode_src;
    assign MUX_ADDR_O = mux_addr;
    assign KBD_O.key_strobe = st_q.kstb;
    assign KBD_O.shift_clock_pulse = (st_q.ks == KS_ONE) != (st_q.ks == KS_TWO && st_q.kdir)
                                     && !(st_q.ks == KS_ONE && st_q.kdir); // RL24
    assign KBD_O.latch_write_pulse = (st_q.ks == KS_ONE && st_q.kdir)
                                     || (st_q.ks == KS_TWO && !st_q.kdir); // RL24
    assign KBD_O.latch_select = st_q.sel; // RL15
    assign KBD_O.digits = st_q.latch; // RL14

    // checks
    sequence s_digit_shift;
        st_q.ks == KS_ONE && !st_q.kdir;
    endsequence
    sequence s_back_write;
        st_q.ks == KS_ONE && st_q.kdir;
    endsequence

    a_attn_drop_ack: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL6
        CABLE_O.attn_req && acc && !gen_rst |=> !CABLE_O.attn_req)
        else $error("attention not dropped on accept");
    a_ready_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL3
        CABLE_O.group_ready && !taken && !gen_rst |=> CABLE_O.group_ready && $stable(CABLE_O.data))
        else $error("group ready dropped before taken");
    a_four_groups: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL9
        st_q.hs == HS_DONE |-> st_q.taken_cnt == LAST_TAKEN)
        else $error("block ended without four groups");
    a_chan_adv_src: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL10
        st_q.hs == HS_DONE && st_q.mode_src && !gen_rst
        |=> CHANNEL_ADVANCE_O ##1 !CHANNEL_ADVANCE_O)
        else $error("channel advance missing in source mode");
    a_manual_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL16
        st_q.hs == HS_DONE && !st_q.mode_src |=> st_q.sel == SEL_HOME && st_q.latch == '0)
        else $error("buffer not cleared after manual block");
    a_sel_onehot: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL15
        $onehot(st_q.sel))
        else $error("selector lost its single one");
    a_digit_order: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL17
        s_digit_shift ##0 !buf_clr |-> KBD_O.shift_clock_pulse ##1 KBD_O.latch_write_pulse)
        else $error("digit key pulses out of order");
    a_back_order: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL18
        s_back_write ##0 !buf_clr |-> KBD_O.latch_write_pulse ##1
        (KBD_O.shift_clock_pulse && st_q.sel == $past(st_q.sel)))
        else $error("backspace pulses out of order");
    a_rx_off_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL12
        gen_rst |=> !RX_ENABLE_O && !MODE_SOURCE_O)
        else $error("receivers or mode not cleared by reset");
    a_mux_range: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) // RL11
        MUX_ADDR_O[2] == MODE_SOURCE_O)
        else $error("mux address outside mode range");
endmodule : shk_station

// [hdl/shk_pkg.sv]
// shared constants, state encodings and carrier types of the station handshake block
// assumes a single 100 MHz system clock and one station per cable
//
// Overview of operation
// RL1 - voltmeter ready raises the attention request
// RL2 - send key raises attention, keyboard buffer follows
// RL3 - handshake signals hold until acknowledged
// RL4 - controller raises host interrupt and device test
// RL5 - controller turns control pulse into accept
// RL6 - accept drops attention, enables cable drivers
// RL7 - controller drops accept on attention fall
// RL8 - group ready once group sits on cable
// RL9 - group taken advances group, four per block
// RL10 - last group: channel advance or buffer clear
// RL11 - mux address from mode and group position
// RL12 - receivers enabled at first attention, off on clear
// RL13 - numeric key gives 1248 BCD and strobe
// RL14 - buffer holds six digits plus exponent
// RL15 - one-hot 8-bit selector picks digit latch
// RL16 - buffer clear homes selector, zeros latches
// RL17 - digit key: shift right, then write
// RL18 - backspace: write zero, then shift left
// RL19 - each backspace clears one more digit
// RL20 - control keys debounced before acting
// RL21 - general reset from key or power-on
// RL22 - eight-digit block sent as four byte groups
// RL23 - mode resets to manual, mode key toggles
// RL24 - stretched pulses become ordered single-cycle pulses
package shk_pkg;
    // pin vector layout, every bit crosses in through the three-stage filter
    localparam int PIN_W = 18;
    localparam int PIN_RECORD = 0;
    localparam int PIN_SEND = 1;
    localparam int PIN_REQUEST = 2;
    localparam int PIN_BACK = 3;
    localparam int PIN_RESET = 4;
    localparam int PIN_MODE = 5;
    localparam int PIN_ACCEPT = 6;
    localparam int PIN_TAKEN = 7;
    localparam int PIN_DIGIT0 = 8;
    localparam int NUM_KEYS = 10;
    // block layout
    localparam int DIGIT_W = 4;
    localparam int GROUP_W = 8;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_LATCH = 7;
    localparam int SEL_W = 8;
    localparam int VM_W = 32;
    localparam int EXP_LATCH = 6;
    localparam logic [SEL_W-1:0] SEL_HOME = 8'h01;
    localparam logic [2:0] LAST_TAKEN = 3'h4;
    localparam logic [2:0] MUX_SRC_BASE = 3'h4;
    localparam logic [DIGIT_W-1:0] FUNC_MANUAL = 4'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    // power-on reset stretch
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_TIME_NS = 200;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_W = 5;

    typedef logic [PIN_W-1:0] shk_pins_t;

    // handshake sequencer, gray along idle-attn-xfer-done
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_ATTN = 2'h1,
        HS_XFER = 2'h3,
        HS_DONE = 2'h2
    } shk_hs_t;

    // keyboard pulse sequencer
    typedef enum logic [1:0] {
        KS_IDLE = 2'h0,
        KS_ONE = 2'h1,
        KS_TWO = 2'h3
    } shk_ks_t;

    typedef struct packed {
        logic attn_req;
        logic driver_enable_line;
        logic group_ready;
        logic [GROUP_W-1:0] data;
    } shk_cable_t;

    typedef struct packed {
        logic key_strobe;
        logic shift_clock_pulse;
        logic latch_write_pulse;
        logic [SEL_W-1:0] latch_select;
        logic [NUM_LATCH-1:0][DIGIT_W-1:0] digits;
    } shk_kbd_t;
endpackage : shk_pkg

// [tb/shk_ctrl_model.sv]
// behavioural controller card facing the station across the cable
// assumes the bench sets the host reaction delay through lag_i, in clock cycles
`timescale 1ns/1ns
module shk_ctrl_model (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic attn_i, // attention request from station
    input wire logic ready_i, // group ready from station
    input wire logic [7:0] data_i, // group on the cable
    input wire logic [7:0] lag_i, // host reaction delay
    output logic accept_o, // held accept acknowledge
    output logic taken_o, // held group taken
    output logic irq_o, // shared host interrupt
    output logic dev_test_o, // per-station device test
    output logic data_test_o, // host data ready test
    output logic [31:0] bytes_o, // last four groups loaded
    output int groups_o // groups loaded since reset
);
    logic [7:0] wait_q;
    logic attn_q;

    // interrupt and device test follow the request directly
    assign irq_o = attn_i;
    assign dev_test_o = attn_i;

    // host program: reacts after lag_i cycles, pulse and strobe become held levels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accept_o <= 1'b0;
            taken_o <= 1'b0;
            data_test_o <= 1'b0;
            bytes_o <= 32'h0000_0000;
            groups_o <= 0;
            wait_q <= 8'h00;
            attn_q <= 1'b0;
        end else begin
            attn_q <= attn_i;
            wait_q <= 8'h00;
            if (irq_o && !accept_o) begin
                if (wait_q == lag_i) accept_o <= 1'b1;
                else wait_q <= wait_q + 8'h01;
            end else if (data_test_o && !taken_o) begin
                if (wait_q == lag_i) begin
                    bytes_o <= {bytes_o[23:0], data_i};
                    groups_o <= groups_o + 1;
                    taken_o <= 1'b1;
                    data_test_o <= 1'b0;
                end else begin
                    wait_q <= wait_q + 8'h01;
                end
            end
            // accept held until the request falls
            if (attn_q && !attn_i) accept_o <= 1'b0;
            // taken held until ready drops, so a slow cable cannot lose it
            if (!ready_i) taken_o <= 1'b0;
            if (ready_i && !taken_o && !data_test_o) data_test_o <= 1'b1;
        end
    end
endmodule : shk_ctrl_model

// [tb/tb_station_handshake_keyboard_entry.sv]
// self-checking bench for the station: keyboard buffer, both transfer modes, request, reset key
// assumes the controller card model in shk_ctrl_model and the pin filter latency of the station
`timescale 1ns/1ns
module tb_station_handshake_keyboard_entry;
    import shk_pkg::*;
    localparam logic [15:0] P_RECORD = 16'h0400;
    localparam logic [15:0] P_SEND = 16'h0800;
    localparam logic [15:0] P_REQ = 16'h1000;
    localparam logic [15:0] P_BACK = 16'h2000;
    localparam logic [15:0] P_RST = 16'h4000;
    localparam logic [15:0] P_MODE = 16'h8000;
    logic clk, rst_n, rx_en, adv, mode_src, accept, taken, attn_q, drv_q, rdy_q;
    logic [15:0] pins;
    logic [31:0] vm, got;
    logic [7:0] lag;
    logic [2:0] mux;
    shk_cable_t cable;
    shk_kbd_t kbd;
    int groups, miscompares, check_count, adv_cnt, strobe_cnt, attn_cnt, drv_cnt, s;
    int sc_cnt, wr_cnt, rdy_cnt;

    shk_station dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .RECORD_CMD_I(pins[10]), .KEY_SEND_I(pins[11]),
        .KEY_REQUEST_I(pins[12]), .KEY_BACK_I(pins[13]), .KEY_RESET_I(pins[14]),
        .KEY_MODE_I(pins[15]), .KEY_DIGIT_I(pins[9:0]), .VM_DATA_I(vm),
        .ACCEPT_ACK_I(accept), .GROUP_TAKEN_I(taken), .CABLE_O(cable), .RX_ENABLE_O(rx_en),
        .CHANNEL_ADVANCE_O(adv), .MODE_SOURCE_O(mode_src), .MUX_ADDR_O(mux), .KBD_O(kbd)
    );
    shk_ctrl_model host (
        .clk_i(clk), .rst_n_i(rst_n), .attn_i(cable.attn_req), .ready_i(cable.group_ready),
        .data_i(cable.data), .lag_i(lag), .accept_o(accept), .taken_o(taken), .irq_o(),
        .dev_test_o(), .data_test_o(), .bytes_o(got), .groups_o(groups)
    );

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // event counters, sampled before the edge's own updates land
    always @(posedge clk) begin
        if (adv === 1'b1) adv_cnt++;
        if (kbd.key_strobe === 1'b1) strobe_cnt++;
        if (cable.attn_req === 1'b1 && attn_q !== 1'b1) attn_cnt++;
        if (cable.driver_enable_line === 1'b1 && drv_q !== 1'b1) drv_cnt++;
        if (cable.group_ready === 1'b1 && rdy_q !== 1'b1) rdy_cnt++;
        if (kbd.shift_clock_pulse === 1'b1) sc_cnt++;
        if (kbd.latch_write_pulse === 1'b1) wr_cnt++;
        attn_q = cable.attn_req;
        drv_q = cable.driver_enable_line;
        rdy_q = cable.group_ready;
    end

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // a press held well past the input filter, then a release of the same length
    task tap(input logic [15:0] v);
        pins = v;
        step(8);
        pins = 16'h0000;
        step(8);
    endtask : tap

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // bounded wait on the partner's group count
    task wait_groups(input int n);
        for (int i = 0; i < 4000 && groups < n; i++) step(1);
        check(groups, n);
    endtask : wait_groups

    task finish_test;
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task t_reset_vals;
        check(mode_src, 1'b0);
        check(kbd.latch_select, SEL_HOME);
        check(rx_en, 1'b0);
        check(cable.attn_req, 1'b0);
    endtask : t_reset_vals

    task t_entry_back;
        tap(16'h0008);
        tap(16'h0020);
        check(kbd.digits[0], 4'h3);
        check(kbd.digits[1], 4'h5);
        check(kbd.latch_select, 8'h04);
        check(strobe_cnt, 2);
        check(sc_cnt, 2);
        check(wr_cnt, 2);
        tap(P_BACK);
        check(kbd.digits[1], 4'h0);
        check(kbd.latch_select, 8'h02);
        tap(P_BACK);
        check(kbd.digits[0], 4'h0);
        check(kbd.latch_select, 8'h01);
        tap(P_BACK);
        check(kbd.latch_select, 8'h01);
        check(sc_cnt, 4);
        check(wr_cnt, 4);
    endtask : t_entry_back

    task t_fill_send;
        for (int k = 1; k <= 7; k++) tap(16'h0001 << k);
        check(kbd.digits[6], 4'h7);
        check(kbd.latch_select, 8'h80);
        s = strobe_cnt;
        tap(16'h0200);
        check(strobe_cnt, s);
        check(kbd.digits[6], 4'h7);
        check(mux[2], 1'b0);
        tap(P_SEND);
        wait_groups(4);
        check(got, 32'h0712_3456);
        check(rdy_cnt, 4);
        check(rx_en, 1'b1);
        check(drv_cnt, 1);
        step(10);
        check(kbd.digits, 28'h000_0000);
        check(kbd.latch_select, SEL_HOME);
        check(adv_cnt, 0);
        check(mux, 3'h0);
    endtask : t_fill_send

    // slow host so the station must hold every handshake level
    task t_source;
        tap(P_MODE);
        check(mode_src, 1'b1);
        check(mux[2], 1'b1);
        vm = 32'h1234_5678;
        lag = 8'h28;
        step(5);
        tap(P_RECORD);
        wait_groups(8);
        check(got, 32'h1234_5678);
        check(rdy_cnt, 8);
        step(10);
        check(adv_cnt, 1);
        check(cable.driver_enable_line, 1'b0);
        check(mux, 3'h4);
    endtask : t_source

    // request raises attention only, no drivers and no groups
    task t_request;
        lag = 8'h00;
        s = attn_cnt;
        tap(P_REQ);
        step(20);
        check(attn_cnt, s + 1);
        check(cable.attn_req, 1'b0);
        check(drv_cnt, 2);
        check(groups, 8);
    endtask : t_request

    // reset key: general reset from source mode with two digits in the buffer
    task t_reset_key;
        tap(16'h0100);
        tap(16'h0001);
        check(kbd.digits[0], 4'h8);
        check(kbd.latch_select, 8'h04);
        tap(P_RST);
        step(30);
        check(mode_src, 1'b0);
        check(rx_en, 1'b0);
        check(kbd.digits, 28'h000_0000);
        check(kbd.latch_select, SEL_HOME);
    endtask : t_reset_key

    // main sequence: hold reset, let the power-on stretch run out, then the scenarios
    initial begin
        rst_n = 1'b0;
        pins = 16'h0000;
        vm = 32'h0000_0000;
        lag = 8'h03;
        miscompares = 0;
        check_count = 0;
        step(12);
        rst_n = 1'b1;
        step(25);
        t_reset_vals();
        t_entry_back();
        t_fill_send();
        t_source();
        t_request();
        t_reset_key();
        finish_test();
    end

    // watchdog: the scenarios need a few thousand cycles at most
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
endmodule : tb_station_handshake_keyboard_entry
